/* shared/smbus_ctl_pkg.sv */
/*
 * Constants for the second SMBus port control and status register:
 * register offset, bit positions, reset value and bus widths.
 * Assumes a 32-bit APB register bus with byte addressing.
 */
package smbus_ctl_pkg;

    // Bus geometry
    localparam int          APB_DATA_W = 32;
    localparam int          CTL_W      = 8;

    // Register map, byte address of the one control word
    localparam logic [11:0] CTL_OFFSET = 12'h000;

    // Field positions inside the control word
    localparam int          MASTER_BIT = 7;
    localparam int          TXMODE_BIT = 6;
    localparam int          START_BIT  = 5;
    localparam int          STOP_BIT   = 4;
    localparam int          ACKRQ_BIT  = 3;
    localparam int          ARB_BIT    = 2;
    localparam int          ACK_BIT    = 1;
    localparam int          IRQ_BIT    = 0;

    // Reset value of the whole control word
    localparam logic [7:0]  CTL_RESET  = 8'h00;

    // Level driven on the clock line while it is held
    localparam logic        SCL_HOLD_LEVEL = 1'b0;

endpackage : smbus_ctl_pkg

/* hw/smbus_apb_slave.sv */
/*
 * Zero-wait APB slave for one control word.
 * Assumes a standard APB master; read data is captured in the
 * setup cycle so prdata comes from a flip-flop in the access cycle.
 */
module smbus_apb_slave
    import smbus_ctl_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic                                clk_sys_i,
    input  wire logic                                rst_b_i,
    // APB
    input  wire logic                                psel_i,
    input  wire logic                                penable_i,
    input  wire logic                                pwrite_i,
    input  wire logic [ADDR_W-1:0]                   paddr_i,
    input  wire logic [smbus_ctl_pkg::APB_DATA_W-1:0] pwdata_i,
    output logic      [smbus_ctl_pkg::APB_DATA_W-1:0] prdata_o,
    output logic                                     pready_o,
    output logic                                     pslverr_o,
    // Register side
    input  wire logic [smbus_ctl_pkg::CTL_W-1:0]     reg_rdata_i,
    output logic                                     reg_wr_o,
    output logic      [smbus_ctl_pkg::CTL_W-1:0]     reg_wdata_o
);
    import smbus_ctl_pkg::*;

    logic                  addr_hit;
    logic                  setup_rd;
    logic                  access;
    logic [APB_DATA_W-1:0] prdata_reg;

    // Decode; unmapped addresses answer with an error
    assign addr_hit    = (paddr_i == ADDR_W'(CTL_OFFSET));
    assign setup_rd    = psel_i & ~penable_i & ~pwrite_i;
    assign access      = psel_i & penable_i;
    assign pready_o    = 1'b1;
    assign pslverr_o   = access & ~addr_hit;
    assign reg_wr_o    = access & pwrite_i & addr_hit;
    assign reg_wdata_o = pwdata_i[CTL_W-1:0];
    assign prdata_o    = prdata_reg;

    // Capture read data at setup; upper bits read as zero
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            prdata_reg <= '0;
        end else if (setup_rd) begin
            prdata_reg <= addr_hit ? {{(APB_DATA_W-CTL_W){1'b0}}, reg_rdata_i} : '0;
        end
    end

endmodule : smbus_apb_slave

/* hw/smbus_control_status.sv */
/*
 * Control and status register of the second SMBus port, with the
 * flag logic that ties software requests to the bit engine.
 * Assumes an external bit engine that reports bus events as one-cycle
 * pulses synchronous to clk_sys_i, and a 32-bit APB master.
 */
// Design decisions made here: the APB register port and the placing of the registers.
// Contract
// - Bit 7 reads one while bus master
// - Generating START sets master indicator
// - Bit 6 reads one while transmitting
// - Data write before frame sets transmit
// - Start flag reports starts; write requests START
// - Slave START plus address sets start flag
// - Stop flag: slave stop seen, master pending
// - Master stop write; cleared after STOP sent
// - Slave stop or stop arbitration sets flag
// - Acknowledge request on byte, software ack only
// - Unwanted repeated START loses arbitration
// - Clock low during STOP/restart loses arbitration
// - Data low while driving one loses
// - Ack bit reads sample, write selects reply
// - Hardware sets interrupt flag; software clears
// - Interrupt flag holds clock low, stalls
// - Write zero clears and advances; one forces
// - Hardware ack enable: auto ack, no request
module smbus_control_status
    import smbus_ctl_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic                                clk_sys_i,
    input  wire logic                                rst_b_i,
    // APB register bus
    input  wire logic                                psel_i,
    input  wire logic                                penable_i,
    input  wire logic                                pwrite_i,
    input  wire logic [ADDR_W-1:0]                   paddr_i,
    input  wire logic [smbus_ctl_pkg::APB_DATA_W-1:0] pwdata_i,
    output logic      [smbus_ctl_pkg::APB_DATA_W-1:0] prdata_o,
    output logic                                     pready_o,
    output logic                                     pslverr_o,
    // Sampled bus lines
    input  wire logic                                bus_clock_line_i,
    input  wire logic                                bus_data_line_i,
    // Bit engine events, one-cycle pulses
    input  wire logic                                start_generated_i,
    input  wire logic                                start_received_i,
    input  wire logic                                stop_generated_i,
    input  wire logic                                stop_detected_i,
    input  wire logic                                stop_arb_lost_i,
    input  wire logic                                rep_start_detected_i,
    input  wire logic                                byte_received_i,
    input  wire logic                                ack_sample_i,
    input  wire logic                                bit_sample_i,
    // Bit engine phase levels
    input  wire logic                                stop_rs_attempt_i,
    input  wire logic                                driving_one_i,
    input  wire logic                                ack_phase_i,
    input  wire logic                                frame_active_i,
    input  wire logic                                data_reg_written_i,
    input  wire logic                                hardware_acknowledge_enable_i,
    // Requests to the bit engine
    output logic                                     start_request_o,
    output logic                                     stop_request_o,
    output logic                                     ack_send_o,
    output logic                                     auto_ack_o,
    output logic                                     next_event_o,
    output logic                                     bus_stall_o,
    // Clock line pin
    output logic                                     bus_clock_line_o,
    output logic                                     bus_clock_line_oe_o
);
    import smbus_ctl_pkg::*;

    // Widths the decode cannot serve are refused
    if (ADDR_W < 3 || ADDR_W > 12) begin : g_bad_addr_w
        $error("ADDR_W must lie between 3 and 12");
    end

    logic             reg_wr;
    logic [CTL_W-1:0] reg_wdata;
    logic [CTL_W-1:0] ctl_rdata;

    logic master_reg,     master_next;
    logic txmode_reg,     txmode_next;
    logic start_flag_reg, start_flag_next;
    logic start_req_reg,  start_req_next;
    logic stop_flag_reg,  stop_flag_next;
    logic ackrq_reg,      ackrq_next;
    logic arb_reg,        arb_next;
    logic ack_reg,        ack_next;
    logic irq_reg,        irq_next;
    logic next_ev_reg,    next_ev_next;

    // Bus slave
    smbus_apb_slave #(
        .ADDR_W      (ADDR_W)
    ) u_apb (
        .clk_sys_i   (clk_sys_i),
        .rst_b_i     (rst_b_i),
        .psel_i      (psel_i),
        .penable_i   (penable_i),
        .pwrite_i    (pwrite_i),
        .paddr_i     (paddr_i),
        .pwdata_i    (pwdata_i),
        .prdata_o    (prdata_o),
        .pready_o    (pready_o),
        .pslverr_o   (pslverr_o),
        .reg_rdata_i (ctl_rdata),
        .reg_wr_o    (reg_wr),
        .reg_wdata_o (reg_wdata)
    );

    // Software write strobes per field
    logic wr_start1, wr_start0, wr_stop1, wr_stop0;
    logic wr_irq1, wr_irq0;
    assign wr_start1 = reg_wr & reg_wdata[START_BIT];
    assign wr_start0 = reg_wr & ~reg_wdata[START_BIT];
    assign wr_stop1  = reg_wr & reg_wdata[STOP_BIT] & master_reg;
    assign wr_stop0  = reg_wr & ~reg_wdata[STOP_BIT];
    assign wr_irq1   = reg_wr & reg_wdata[IRQ_BIT];
    assign wr_irq0   = reg_wr & ~reg_wdata[IRQ_BIT];

    // Arbitration loss causes
    logic rs_unwanted, scl_lost, sda_lost, arb_event;
    assign rs_unwanted = rep_start_detected_i & master_reg & ~start_flag_reg;
    assign scl_lost    = bit_sample_i & stop_rs_attempt_i & ~bus_clock_line_i;
    assign sda_lost    = bit_sample_i & driving_one_i & ~ack_phase_i
                       & ~bus_data_line_i;
    assign arb_event   = rs_unwanted | scl_lost | sda_lost | stop_arb_lost_i;

    // Events that raise the interrupt flag
    logic rx_byte_sw, hw_irq_set, irq_clear;
    assign rx_byte_sw  = byte_received_i & ~hardware_acknowledge_enable_i;
    assign hw_irq_set  = start_generated_i | start_received_i | stop_detected_i
                       | arb_event | rx_byte_sw | ack_sample_i;
    // Clearing only counts when no event lands in the same cycle
    assign irq_clear   = wr_irq0 & ~hw_irq_set;

    // Master and transmit indicators; hardware sets win
    assign master_next = start_generated_i ? 1'b1 :
                         (stop_generated_i | arb_event) ? 1'b0 : master_reg;
    assign txmode_next = (data_reg_written_i & ~frame_active_i) ? 1'b1 :
                         (start_received_i | arb_event) ? 1'b0 : txmode_reg;

    // Start flag and the separate request to the engine
    assign start_flag_next = (wr_start1 | start_received_i) ? 1'b1 :
                             wr_start0 ? 1'b0 : start_flag_reg;
    assign start_req_next  = wr_start1 ? 1'b1 :
                             start_generated_i ? 1'b0 : start_req_reg;

    // Stop flag: hardware clears it once the STOP is out
    assign stop_flag_next = (wr_stop1 | stop_detected_i | stop_arb_lost_i) ? 1'b1 :
                            (stop_generated_i | wr_stop0) ? 1'b0 : stop_flag_reg;

    // Request and arbitration flags live until the interrupt clears
    assign ackrq_next = rx_byte_sw ? 1'b1 : irq_clear ? 1'b0 : ackrq_reg;
    assign arb_next   = arb_event ? 1'b1 : irq_clear ? 1'b0 : arb_reg;

    // Ack bit: a sample overrides a write in the same cycle
    assign ack_next = ack_sample_i ? ~bus_data_line_i :
                      reg_wr ? reg_wdata[ACK_BIT] : ack_reg;

    // Interrupt flag: set wins over software clear
    assign irq_next     = (hw_irq_set | wr_irq1) ? 1'b1 :
                          irq_clear ? 1'b0 : irq_reg;
    assign next_ev_next = irq_clear & irq_reg;

    // Control word state, all zero after reset
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            {master_reg, txmode_reg, start_flag_reg, stop_flag_reg,
             ackrq_reg, arb_reg, ack_reg, irq_reg} <= CTL_RESET;
            start_req_reg <= 1'b0;
            next_ev_reg   <= 1'b0;
        end else begin
            master_reg     <= master_next;
            txmode_reg     <= txmode_next;
            start_flag_reg <= start_flag_next;
            stop_flag_reg  <= stop_flag_next;
            ackrq_reg      <= ackrq_next;
            arb_reg        <= arb_next;
            ack_reg        <= ack_next;
            irq_reg        <= irq_next;
            start_req_reg  <= start_req_next;
            next_ev_reg    <= next_ev_next;
        end
    end

    // Read view of the control word
    assign ctl_rdata = {master_reg, txmode_reg, start_flag_reg,
                        stop_flag_reg, ackrq_reg, arb_reg, ack_reg, irq_reg};

    // Engine requests; stop only counts while master
    assign start_request_o = start_req_reg;
    assign stop_request_o  = stop_flag_reg & master_reg;
    assign ack_send_o      = ack_reg;
    assign auto_ack_o      = hardware_acknowledge_enable_i;
    assign next_event_o    = next_ev_reg;

    // Holding the clock line low stalls every other party
    assign bus_stall_o         = irq_reg;
    assign bus_clock_line_o    = SCL_HOLD_LEVEL;
    assign bus_clock_line_oe_o = irq_reg;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_setup_rd;
        psel_i && !penable_i && !pwrite_i && paddr_i == ADDR_W'(CTL_OFFSET);
    endsequence
    sequence s_access;
        psel_i && penable_i;
    endsequence
    sequence s_clear_write;
        reg_wr && !reg_wdata[IRQ_BIT] && !hw_irq_set && irq_reg;
    endsequence

    a_master_readback: assert property (s_setup_rd ##1 s_access
        |-> prdata_o[MASTER_BIT] == $past(master_reg))
        else $error("master indicator read wrong");
    a_master_on_start: assert property (start_generated_i
        |=> master_reg)
        else $error("master not set by START");
    a_txmode_readback: assert property (s_setup_rd ##1 s_access
        |-> prdata_o[TXMODE_BIT] == $past(txmode_reg))
        else $error("transmit indicator read wrong");
    a_txmode_on_write: assert property (data_reg_written_i && !frame_active_i
        |=> txmode_reg)
        else $error("transmit mode not set");
    a_start_request: assert property (reg_wr && reg_wdata[START_BIT]
        |=> start_request_o && start_flag_reg)
        else $error("START not requested");
    a_start_slave: assert property (start_received_i |=> start_flag_reg)
        else $error("start flag not set as slave");
    a_stop_pending: assert property (stop_request_o |-> master_reg && stop_flag_reg)
        else $error("stop request without master");
    a_stop_hw_clear: assert property (stop_generated_i && !stop_detected_i
        && !stop_arb_lost_i && !wr_stop1 |=> !stop_flag_reg && !stop_request_o)
        else $error("stop flag not cleared");
    a_stop_detect: assert property (stop_detected_i || stop_arb_lost_i
        |=> stop_flag_reg)
        else $error("stop flag not set on detect");
    a_ackrq_gate: assert property (byte_received_i
        |=> ackrq_reg == (!$past(hardware_acknowledge_enable_i) || $past(ackrq_reg)
            && !$past(irq_clear)))
        else $error("acknowledge request wrong");
    a_arb_restart: assert property (rep_start_detected_i && master_reg
        && !start_flag_reg |=> arb_reg && irq_reg && !master_reg)
        else $error("unwanted restart not flagged");
    a_arb_clock: assert property (bit_sample_i && stop_rs_attempt_i
        && !bus_clock_line_i |=> arb_reg)
        else $error("clock loss not flagged");
    a_arb_data: assert property (bit_sample_i && driving_one_i && !ack_phase_i
        && !bus_data_line_i |=> arb_reg ##1 (arb_reg || $past(irq_clear)))
        else $error("data loss not flagged");
    a_ack_sample: assert property (ack_sample_i
        |=> ack_reg == !$past(bus_data_line_i) && ack_send_o == ack_reg)
        else $error("ack sample not captured");
    a_irq_set_wins: assert property (hw_irq_set && reg_wr
        |=> irq_reg)
        else $error("event lost against clear");
    a_irq_holds_scl: assert property (irq_reg
        |-> bus_clock_line_oe_o && !bus_clock_line_o && bus_stall_o)
        else $error("clock line not held");
    a_irq_advance: assert property (s_clear_write
        |=> !irq_reg && next_event_o ##1 !next_event_o)
        else $error("clear did not advance");
    a_hwack_no_rq: assert property (hardware_acknowledge_enable_i && !ackrq_reg
        && !byte_received_i ##1 hardware_acknowledge_enable_i[*2] |-> !ackrq_reg)
        else $error("request raised under hardware ack");
    a_reset_zero: assert property (disable iff (1'b0) !rst_b_i
        |=> ctl_rdata == CTL_RESET && !start_request_o)
        else $error("control word not zero after reset");

endmodule : smbus_control_status

/* tb/smbus_bus_model.sv */
/*
 * Model of the two-wire bus beyond the port: pulled-up clock and data
 * lines shared with other masters and slaves.
 * Assumes the bench tells it when another party pulls a line low.
 */
module smbus_bus_model (
    // Port's clock line pin
    input  wire logic scl_drv_i,
    input  wire logic scl_oe_i,
    // Other parties pulling lines low
    input  wire logic other_scl_low_i,
    input  wire logic other_sda_low_i,
    // Wired line levels
    output logic      scl_o,
    output logic      sda_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Wired-and with pull-ups, so a released line reads high
    assign scl_o = ((scl_oe_i & ~scl_drv_i) | other_scl_low_i) ? 1'h0 : 1'h1;
    assign sda_o = other_sda_low_i ? 1'h0 : 1'h1;
endmodule : smbus_bus_model

/* tb/tb_top.sv */
/*
 * Self-checking bench for the control and status register.
 * Assumes the zero-wait APB slave and one-cycle engine event pulses.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import smbus_ctl_pkg::*;

    localparam logic [9:0] E_SG = 10'h001, E_SR = 10'h002, E_PG = 10'h004, E_PD = 10'h008;
    localparam logic [9:0] E_PA = 10'h010, E_RS = 10'h020, E_BR = 10'h040, E_AK = 10'h080;
    localparam logic [9:0] E_BS = 10'h100, E_DW = 10'h200;

    logic        clk_sys_i, rst_b_i, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [9:0]  ev;
    logic [3:0]  lv;
    logic        hwack, oth_scl, oth_sda, scl_w, sda_w, scl_drv, scl_oe;
    logic        start_req, stop_req, ack_send, auto_ack, next_ev, stall;
    integer      seed = 39;
    integer      miscompares = 0;
    integer      n_checks = 0;
    int          i;
    logic [7:0]  w;

    smbus_control_status smbus_control_status_inst (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .bus_clock_line_i(scl_w),
        .bus_data_line_i(sda_w), .start_generated_i(ev[0]), .start_received_i(ev[1]),
        .stop_generated_i(ev[2]), .stop_detected_i(ev[3]), .stop_arb_lost_i(ev[4]),
        .rep_start_detected_i(ev[5]), .byte_received_i(ev[6]), .ack_sample_i(ev[7]),
        .bit_sample_i(ev[8]), .stop_rs_attempt_i(lv[3]), .driving_one_i(lv[2]),
        .ack_phase_i(lv[1]), .frame_active_i(lv[0]), .data_reg_written_i(ev[9]),
        .hardware_acknowledge_enable_i(hwack), .start_request_o(start_req),
        .stop_request_o(stop_req), .ack_send_o(ack_send), .auto_ack_o(auto_ack),
        .next_event_o(next_ev), .bus_stall_o(stall), .bus_clock_line_o(scl_drv),
        .bus_clock_line_oe_o(scl_oe));

    smbus_bus_model smbus_bus_model_inst (
        .scl_drv_i(scl_drv), .scl_oe_i(scl_oe), .other_scl_low_i(oth_scl),
        .other_sda_low_i(oth_sda), .scl_o(scl_w), .sda_o(sda_w));

    // Free-running system clock
    initial begin
        clk_sys_i = 1'h0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic print_verdict;
        if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Expected control word from its fields
    function automatic logic [31:0] ctlw(input logic m, t, s, p, q, a, k, i);
        return {24'h0, m, t, s, p, q, a, k, i};
    endfunction : ctlw

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_i);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            miscompares++;
            print_verdict();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        #1;
    endtask : apb

    task automatic wr(input logic [7:0] d);
        apb(1'h1, CTL_OFFSET, {24'h0, d});
    endtask : wr

    task automatic expc(input logic [31:0] x);
        apb(1'h0, CTL_OFFSET, 32'h0);
        check(r, x);
    endtask : expc

    task automatic pulse(input logic [9:0] m, input logic [3:0] l);
        @(posedge clk_sys_i);
        ev <= m;
        lv <= l;
        @(posedge clk_sys_i);
        ev <= '0;
        lv <= '0;
        #1;
    endtask : pulse

    // Start request, START generated, interrupt cleared: port is master
    task automatic become_master;
        wr(8'h20);
        pulse(E_SG, 4'h0);
        wr(8'h00);
    endtask : become_master

    initial begin
        {rst_b_i, psel, penable, pwrite, hwack, oth_scl, oth_sda} = '0;
        paddr = '0;
        pwdata = '0;
        ev = '0;
        lv = '0;
        repeat (2) @(posedge clk_sys_i);
        rst_b_i <= 1'h1;
        expc(ctlw(0, 0, 0, 0, 0, 0, 0, 0));
        // Unmapped addresses refused, read-only and ack bits at random
        for (i = 0; i < 12; i++) begin
            apb(1'h1, 12'(((($random(seed) & 32'h3ff) % 1023) + 1) << 2), 32'hff);
            check({31'h0, e}, 32'h1);
            w = 8'($random(seed)) & 8'hce;
            wr(w);
            check({31'h0, ack_send}, {31'h0, w[1]});
            expc(ctlw(0, 0, 0, 0, 0, 0, w[1], 0));
        end
        wr(8'h00);
        // Data write before a frame, then slave START
        pulse(E_DW, 4'h1);
        expc(ctlw(0, 0, 0, 0, 0, 0, 0, 0));
        pulse(E_DW, 4'h0);
        expc(ctlw(0, 1, 0, 0, 0, 0, 0, 0));
        pulse(E_SR, 4'h0);
        check({30'h0, scl_oe, scl_w}, 32'h2);
        check({31'h0, stall}, 32'h1);
        expc(ctlw(0, 0, 1, 0, 0, 0, 0, 1));
        wr(8'h00);
        check({31'h0, next_ev}, 32'h1);
        @(posedge clk_sys_i);
        #1;
        check({30'h0, next_ev, scl_w}, 32'h1);
        // Stop write as slave refused; detected STOP sets flag
        wr(8'h10);
        check({31'h0, stop_req}, 32'h0);
        pulse(E_PD, 4'h0);
        expc(ctlw(0, 0, 0, 1, 0, 0, 0, 1));
        wr(8'h00);
        pulse(E_BR, 4'h0);
        expc(ctlw(0, 0, 0, 0, 1, 0, 0, 1));
        wr(8'h00);
        expc(ctlw(0, 0, 0, 0, 0, 0, 0, 0));
        hwack <= 1'h1;
        pulse(E_BR, 4'h0);
        check({31'h0, auto_ack}, 32'h1);
        expc(ctlw(0, 0, 0, 0, 0, 0, 0, 0));
        hwack <= 1'h0;
        // Master START then STOP
        wr(8'h20);
        check({31'h0, start_req}, 32'h1);
        pulse(E_SG, 4'h0);
        check({31'h0, start_req}, 32'h0);
        expc(ctlw(1, 0, 1, 0, 0, 0, 0, 1));
        wr(8'h10);
        check({31'h0, stop_req}, 32'h1);
        expc(ctlw(1, 0, 0, 1, 0, 0, 0, 0));
        pulse(E_PG, 4'h0);
        expc(ctlw(0, 0, 0, 0, 0, 0, 0, 0));
        // Arbitration losses of each kind
        become_master();
        pulse(E_RS, 4'h0);
        expc(ctlw(0, 0, 0, 0, 0, 1, 0, 1));
        wr(8'h00);
        become_master();
        oth_scl <= 1'h1;
        pulse(E_BS, 4'h8);
        oth_scl <= 1'h0;
        expc(ctlw(0, 0, 0, 0, 0, 1, 0, 1));
        wr(8'h00);
        become_master();
        oth_sda <= 1'h1;
        pulse(E_BS, 4'h6);
        expc(ctlw(1, 0, 0, 0, 0, 0, 0, 0));
        pulse(E_BS, 4'h4);
        expc(ctlw(0, 0, 0, 0, 0, 1, 0, 1));
        wr(8'h00);
        pulse(E_AK, 4'h0);
        expc(ctlw(0, 0, 0, 0, 0, 0, 1, 1));
        oth_sda <= 1'h0;
        pulse(E_AK, 4'h0);
        expc(ctlw(0, 0, 0, 0, 0, 0, 0, 1));
        become_master();
        pulse(E_PA, 4'h0);
        expc(ctlw(0, 0, 0, 1, 0, 1, 0, 1));
        wr(8'h01);
        expc(ctlw(0, 0, 0, 0, 0, 1, 0, 1));
        // Reset in mid-run with flags up
        @(posedge clk_sys_i);
        rst_b_i <= 1'h0;
        repeat (2) @(posedge clk_sys_i);
        rst_b_i <= 1'h1;
        #1;
        check({30'h0, stall, scl_oe}, 32'h0);
        expc(ctlw(0, 0, 0, 0, 0, 0, 0, 0));
        print_verdict();
    end
endmodule : tb_top
